// ### pkg/counter_params.svh
// Purpose: Register offsets, field positions and reset values for the edge counter.
// Assumes: Included by bare name after the package is compiled.
// Notes: Definitions only; no logic lives here.
`ifndef COUNTER_PARAMS_SVH
`define COUNTER_PARAMS_SVH

// Register byte offsets on the 4-bit local address.
`define OFF_CTRL      4'h0
`define OFF_PRESET    4'h4
`define OFF_COUNT     4'h8
`define OFF_STATUS    4'hC

// Control register fields.
`define CTRL_EN_LSB   0
`define CTRL_EN_MSB   1
`define CTRL_DIR_SRC  2
`define CTRL_DIR_VAL  3
`define CTRL_RST_VAL  32'h0000_0000

// Preset register reset value and width of the count word.
`define PRESET_RST    16'h0000
`define CNT_WIDTH     16

// Status register bit positions.
`define ST_CNT_IN     0
`define ST_ENABLED    1
`define ST_DIR        2
`define ST_RESET_N    3
`define ST_FAULT      4

// Write responses on the AXI4-Lite channel.
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// ### pkg/counter_pkg.sv
// Purpose: Shared types for the rising-edge up/down counter.
// Assumes: Compiled before any design file.
// Notes: Enable mode codes match the two-bit control field.
`default_nettype none

package counter_pkg;

  // How the enable is sourced; code 2'b11 is not a legal setting.
  typedef enum logic [1:0] {
    EN_FROM_PIN   = 2'b00,
    EN_ALWAYS_ON  = 2'b01,
    EN_ALWAYS_OFF = 2'b10
  } en_mode_t;

  // A full AXI4-Lite data word.
  typedef logic [31:0] word_t;

endpackage

`default_nettype wire

// ### rtl/pin_sync.sv
// Purpose: Two flip-flop synchroniser for a group of asynchronous pins.
// Assumes: Each bit is an independent level; no bus coherence is needed.
// Notes: The first stage feeds only the second stage.
`default_nettype none

module pin_sync #(
  parameter int W = 5
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;    // First stage, may go metastable.
  logic [W-1:0] meta_nxt;  // Next value of the first stage.
  logic [W-1:0] sync_r;    // Second stage, safe to use.
  logic [W-1:0] sync_nxt;  // Next value of the second stage.

  // Next values: each stage copies the one in front of it.
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // Both stages clear under reset so downstream starts from a known low.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule

`default_nettype wire

// ### rtl/rising_edge_updown_counter.sv
// Purpose: 16-bit up/down counter stepping on count input rising edges.
// Assumes: Pins are asynchronous; registers are reached over AXI4-Lite.
// Notes: Pin to count word latency is three clock edges.
`include "counter_params.svh"
`default_nettype none

module rising_edge_updown_counter #(
  parameter int ADDR_W = 4,
  parameter int CNT_W  = `CNT_WIDTH
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              en_pin,
  input  wire logic              count_pin,
  input  wire logic              dir_pin,
  input  wire logic              reset_n_pin,
  input  wire logic              fault_pin,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire counter_pkg::word_t s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  counter_pkg::word_t s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output var  logic [CNT_W-1:0]  count_value
);
  import counter_pkg::*;

  // Synchronised pin levels.
  logic [4:0]       pins_s;      // Packed outputs of the synchroniser.
  logic             en_s;        // Enable pin level.
  logic             cnt_s;       // Count pin level.
  logic             dir_s;       // Direction pin level.
  logic             rstn_s;      // Functional reset, active low.
  logic             fault_s;     // Fallback error level.

  // Counter state.
  logic [CNT_W-1:0] count_r;     // The count word.
  logic [CNT_W-1:0] count_nxt;   // Its next value.
  logic             prev_cnt_r;  // Count input seen on the previous cycle.
  logic             prev_cnt_nxt;
  logic             en_prev_r;   // Enable seen on the previous cycle.
  logic             en_prev_nxt;
  logic             init_r;      // Preset still to be loaded after power-up.
  logic             init_nxt;

  // Decoded controls.
  en_mode_t         en_mode;     // Enable source from the control register.
  logic             en_act;      // Effective enable.
  logic             dir_act;     // Effective direction, 1 counts down.
  logic             rise;        // Genuine 0-to-1 on the count input.
  logic             en_rise;     // Enable rising while count is high.
  logic             step;        // One step this cycle.

  // Register file and bus state.
  word_t            ctrl_r;      // Enable mode and direction source.
  word_t            ctrl_nxt;
  logic [CNT_W-1:0] preset_r;    // Start point of each sequence.
  logic [CNT_W-1:0] preset_nxt;
  logic             awready_r;
  logic             awready_nxt;
  logic             wready_r;
  logic             wready_nxt;
  logic             bvalid_r;
  logic             bvalid_nxt;
  logic [1:0]       bresp_r;
  logic [1:0]       bresp_nxt;
  logic             arready_r;
  logic             arready_nxt;
  logic             rvalid_r;
  logic             rvalid_nxt;
  logic [1:0]       rresp_r;
  logic [1:0]       rresp_nxt;
  word_t            rdata_r;
  word_t            rdata_nxt;
  logic             wr_fire;     // Address and data both taken this edge.
  logic             rd_fire;     // Read address taken this edge.
  word_t            status_w;    // Live status word.

  // Valid local addresses; shared by the read and write decoders.
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a == `OFF_CTRL) || (a == `OFF_PRESET) ||
              (a == `OFF_COUNT) || (a == `OFF_STATUS);
  endfunction

  // Merge write data into an old word under the byte strobes.
  function automatic word_t merge_strb(input word_t old, input word_t data,
                                       input logic [3:0] strb);
    merge_strb = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge_strb[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  // Every external level crosses two flip-flops before use.
  pin_sync #(
    .W (5)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({fault_pin, reset_n_pin, dir_pin, count_pin, en_pin}),
    .sync_out (pins_s)
  );

  assign en_s    = pins_s[0];
  assign cnt_s   = pins_s[1];
  assign dir_s   = pins_s[2];
  assign rstn_s  = pins_s[3];
  assign fault_s = pins_s[4];

  // Enable source, direction and edge decode.
  always_comb begin
    en_mode = en_mode_t'(ctrl_r[`CTRL_EN_MSB:`CTRL_EN_LSB]);
    unique case (en_mode)
      EN_FROM_PIN:   en_act = en_s;
      EN_ALWAYS_ON:  en_act = 1'b1;
      EN_ALWAYS_OFF: en_act = 1'b0;
      // The spare code is treated as disabled, the safe choice.
      default:       en_act = 1'b0;
    endcase
    // The direction may come from the pin or from a fixed setting.
    dir_act = ctrl_r[`CTRL_DIR_SRC] ? ctrl_r[`CTRL_DIR_VAL] : dir_s;
    rise    = cnt_s & ~prev_cnt_r;
    // A high count input at the enable edge counts as an edge.
    en_rise = en_act & ~en_prev_r & cnt_s;
    // Either source yields a single step; they never add up.
    step    = rise | en_rise;
  end

  // Counter next state: fault freezes, disable freezes, reset wins over steps.
  always_comb begin
    count_nxt    = count_r;
    init_nxt     = init_r;
    prev_cnt_nxt = cnt_s;   // Tracked even while disabled.
    en_prev_nxt  = en_act;
    if (fault_s) begin
      // Frozen; counting picks up from here when the error clears.
      count_nxt = count_r;
    end else if (!en_act) begin
      // Held at the value from the moment the block was disabled.
      count_nxt = count_r;
    end else if (init_r || !rstn_s) begin
      // First enabled cycle after power-up, or reset held low.
      count_nxt = preset_r;
      init_nxt  = 1'b0;
    end else if (step) begin
      // The sum wraps naturally in the 16-bit word.
      if (dir_act) begin
        count_nxt = count_r - CNT_W'(1);
      end else begin
        count_nxt = count_r + CNT_W'(1);
      end
    end
  end

  // Counter registers.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_r    <= `PRESET_RST;
      init_r     <= 1'b1;
      prev_cnt_r <= 1'b0;
      en_prev_r  <= 1'b0;
    end else begin
      count_r    <= count_nxt;
      init_r     <= init_nxt;
      prev_cnt_r <= prev_cnt_nxt;
      en_prev_r  <= en_prev_nxt;
    end
  end

  // Live status seen by software.
  always_comb begin
    status_w = '0;
    status_w[`ST_CNT_IN]  = cnt_s;
    status_w[`ST_ENABLED] = en_act;
    status_w[`ST_DIR]     = dir_act;
    status_w[`ST_RESET_N] = rstn_s;
    status_w[`ST_FAULT]   = fault_s;
  end

  // Bus next state. Write ready pulses one cycle after both channels show valid, read ready one cycle after arvalid,
  // which costs a cycle but keeps every bus output on a flip-flop.
  always_comb begin
    ctrl_nxt    = ctrl_r;
    preset_nxt  = preset_r;
    awready_nxt = 1'b0;
    wready_nxt  = 1'b0;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    arready_nxt = 1'b0;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    wr_fire     = s_axi_awvalid & awready_r & s_axi_wvalid & wready_r;
    rd_fire     = s_axi_arvalid & arready_r;
    // Offer ready only when no response is outstanding.
    if (s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r) begin
      awready_nxt = 1'b1;
      wready_nxt  = 1'b1;
    end
    if (wr_fire) begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = addr_ok(s_axi_awaddr) ? `RESP_OKAY : `RESP_SLVERR;
      // The preset is software's to set before counting starts.
      if (s_axi_awaddr == `OFF_CTRL) begin
        ctrl_nxt = merge_strb(ctrl_r, s_axi_wdata, s_axi_wstrb);
      end else if (s_axi_awaddr == `OFF_PRESET) begin
        preset_nxt = CNT_W'(merge_strb(word_t'(preset_r), s_axi_wdata, s_axi_wstrb));
      end
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && !arready_r && !rvalid_r) begin
      arready_nxt = 1'b1;
    end
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = addr_ok(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (s_axi_araddr)
        `OFF_CTRL:   rdata_nxt = ctrl_r;
        `OFF_PRESET: rdata_nxt = word_t'(preset_r);
        `OFF_COUNT:  rdata_nxt = word_t'(count_r);
        `OFF_STATUS: rdata_nxt = status_w;
        default:     rdata_nxt = '0;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // Bus registers.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r    <= `CTRL_RST_VAL;
      preset_r  <= `PRESET_RST;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= `RESP_OKAY;
      rdata_r   <= '0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      preset_r  <= preset_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // Outputs all come from flip-flops.
  assign count_value   = count_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  // Checks on the counter and the write response; all in the one clock domain.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_up_step: assert property (
    en_act && !fault_s && !init_r && rstn_s && step && !dir_act
    |=> count_r == CNT_W'($past(count_r) + CNT_W'(1)))
    else $error("Up step did not add one.");

  a_down_step: assert property (
    en_act && !fault_s && !init_r && rstn_s && step && dir_act
    |=> count_r == CNT_W'($past(count_r) - CNT_W'(1)))
    else $error("Down step did not subtract one.");

  a_reset_loads: assert property (
    en_act && !fault_s && !rstn_s |=> count_r == $past(preset_r))
    else $error("Reset low did not load the preset.");

  a_disabled_hold: assert property (
    !en_act ##1 !en_act |-> $stable(count_r))
    else $error("Count moved while disabled.");

  a_fault_freeze: assert property (
    fault_s |=> count_r == $past(count_r))
    else $error("Count moved during fallback.");

  a_no_edge_hold: assert property (
    en_act && !fault_s && !init_r && rstn_s && !step |=> $stable(count_r))
    else $error("Count moved without an edge.");

  a_enable_step: assert property (
    en_act && !en_prev_r && cnt_s && prev_cnt_r && !fault_s && !init_r && rstn_s
    |=> count_r != $past(count_r))
    else $error("Enable rise with count high did not step.");

  a_wrap_up: assert property (
    en_act && !fault_s && !init_r && rstn_s && step && !dir_act && count_r == '1
    |=> count_r == '0)
    else $error("Up count did not wrap to zero.");

  a_prev_tracks: assert property (
    !en_act ##1 1'b1 |-> prev_cnt_r == $past(cnt_s))
    else $error("Previous sample stalled while disabled.");

  a_write_resp: assert property (
    wr_fire |=> s_axi_bvalid ##0 !s_axi_awready)
    else $error("Write response missing after handshake.");

  c_up_wrap: cover property (
    step && !dir_act && count_r == '1 && en_act && rstn_s && !fault_s);
  c_reset_load: cover property (en_act && !rstn_s && count_r != preset_r);
  c_enable_rise: cover property (en_rise && !prev_cnt_r);
  c_down_step: cover property (step && dir_act && en_act && rstn_s);

endmodule

`default_nettype wire

// ### sim/island_io_model.sv
// Purpose: Pin-side source model standing in for the island I/O modules.
// Assumes: The bench drives it through its tasks only.
// Notes: Pins change only by non-blocking assignment right after a rising edge.
`default_nettype none

module island_io_model (
  input  wire logic sys_clk,
  output var  logic en_pin,
  output var  logic count_pin,
  output var  logic dir_pin,
  output var  logic reset_n_pin,
  output var  logic fault_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // Start-up levels; the count source idles low so enabling cannot step once.
  initial begin
    en_pin      = 1'b0;
    count_pin   = 1'b0;
    dir_pin     = 1'b0;
    reset_n_pin = 1'b1;
    fault_pin   = 1'b0;
  end

  // Sets the level pins together; the count pin is left as it is.
  task automatic set_pins(input logic en, input logic dir, input logic rn, input logic flt);
    @(posedge sys_clk);
    en_pin      <= en;
    dir_pin     <= dir;
    reset_n_pin <= rn;
    fault_pin   <= flt;
  endtask

  // Moves the count pin to a level and keeps it there.
  task automatic set_count(input logic v);
    @(posedge sys_clk);
    count_pin <= v;
  endtask

  // Sends whole pulses, two cycles high and two low, well above the synchroniser minimum.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      count_pin <= 1'b1;
      repeat (2) @(posedge sys_clk);
      count_pin <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
endmodule

`default_nettype wire

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the rising-edge up/down counter.
// Assumes: Register access over AXI4-Lite, pins from the island model.
// Notes: Pin effects are judged after a settle wait longer than the three-edge latency.
`include "counter_params.svh"
`default_nettype none

module tb_top import counter_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic       sys_clk = 1'b0;    // 20 MHz system clock.
  logic       rst;               // Synchronous reset, high at start.
  logic [3:0] s_axi_awaddr;
  logic       s_axi_awvalid;
  logic       s_axi_awready;
  word_t      s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic       s_axi_wvalid;
  logic       s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic       s_axi_bvalid;
  logic       s_axi_bready;
  logic [3:0] s_axi_araddr;
  logic       s_axi_arvalid;
  logic       s_axi_arready;
  word_t      s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic       s_axi_rvalid;
  logic       s_axi_rready;
  logic [15:0] count_value;
  logic en_pin, count_pin, dir_pin, reset_n_pin, fault_pin;
  int mismatches = 0;            // Failed comparisons.
  int samples_checked = 0;       // All comparisons made.
  logic [1:0] resp;              // Last write response code.
  word_t rd;                     // Last read data.
  logic [1:0] rd_resp;           // Last read response code.

  rising_edge_updown_counter rising_edge_updown_counter_i (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .en_pin        (en_pin),
    .count_pin     (count_pin),
    .dir_pin       (dir_pin),
    .reset_n_pin   (reset_n_pin),
    .fault_pin     (fault_pin),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .count_value   (count_value)
  );

  island_io_model island_io_model_i (
    .sys_clk     (sys_clk),
    .en_pin      (en_pin),
    .count_pin   (count_pin),
    .dir_pin     (dir_pin),
    .reset_n_pin (reset_n_pin),
    .fault_pin   (fault_pin)
  );

  // Half period of 25 ns gives the 50 ns clock.
  always #25 sys_clk = ~sys_clk;

  // Counts and reports one comparison.
  task automatic chk(input string what, input word_t exp, input word_t got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One write; address and data stay up until each is taken, bready until bvalid.
  task automatic axi_wr(input logic [3:0] a, input word_t d, input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50) chk("write wait", 32'h0000_0000, 32'h0000_0001);
  endtask

  // One read; arvalid stays up until taken, rready until rvalid.
  task automatic axi_rd(input logic [3:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rd = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) chk("read wait", 32'h0000_0000, 32'h0000_0001);
  endtask

  // Waits past the pin synchroniser and counter pipeline.
  task automatic settle();
    repeat (6) @(posedge sys_clk);
  endtask

  // Checks the count word against an expected value.
  task automatic chk_cnt(input logic [15:0] exp);
    settle();
    chk("count_value", {16'h0000, exp}, {16'h0000, count_value});
  endtask

  // Reset values of the output and of the writable registers.
  task automatic s_reset();
    chk_cnt(16'h0000);
    axi_rd(`OFF_CTRL);
    chk("ctrl", 32'h0000_0000, rd);
    chk("rresp", {30'h0, `RESP_OKAY}, {30'h0, rd_resp});
    axi_rd(`OFF_PRESET);
    chk("preset", 32'h0000_0000, rd);
  endtask

  // Preset near the top, power-up load, then up-count through the wrap.
  task automatic s_up_wrap();
    axi_wr(`OFF_PRESET, 32'h0000_FFFE);
    chk("bresp", {30'h0, `RESP_OKAY}, {30'h0, resp});
    island_io_model_i.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
    chk_cnt(16'hFFFE);
    island_io_model_i.pulse(3);
    chk_cnt(16'h0001);
    axi_rd(`OFF_COUNT);
    chk("count reg", 32'h0000_0001, rd);
  endtask

  // Down-count through zero, then functional reset and restart from preset.
  task automatic s_down_reset();
    island_io_model_i.set_pins(1'b1, 1'b1, 1'b1, 1'b0);
    island_io_model_i.pulse(2);
    chk_cnt(16'hFFFF);
    island_io_model_i.set_pins(1'b1, 1'b1, 1'b0, 1'b0);
    island_io_model_i.pulse(2);
    chk_cnt(16'hFFFE);
    island_io_model_i.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
    island_io_model_i.pulse(1);
    chk_cnt(16'hFFFF);
  endtask

  // Edges lost while disabled; a high count at enable rise steps exactly once.
  task automatic s_enable();
    island_io_model_i.set_pins(1'b0, 1'b0, 1'b1, 1'b0);
    island_io_model_i.pulse(2);
    island_io_model_i.set_count(1'b1);
    chk_cnt(16'hFFFF);
    island_io_model_i.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
    chk_cnt(16'h0000);
    // Count high, enabled, up, reset released, no fault.
    axi_rd(`OFF_STATUS);
    chk("status", 32'h0000_000B, rd);
    island_io_model_i.set_count(1'b0);
    chk_cnt(16'h0000);
  endtask

  // Fault freezes the word; counting resumes from the frozen value.
  task automatic s_fault();
    island_io_model_i.set_pins(1'b1, 1'b0, 1'b1, 1'b1);
    island_io_model_i.pulse(2);
    chk_cnt(16'h0000);
    island_io_model_i.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
    island_io_model_i.pulse(1);
    chk_cnt(16'h0001);
  endtask

  // Every enable mode and the fixed direction source, then a read-only write.
  task automatic s_modes();
    island_io_model_i.set_pins(1'b0, 1'b0, 1'b1, 1'b0);
    axi_wr(`OFF_CTRL, 32'h0000_0001);
    island_io_model_i.pulse(1);
    chk_cnt(16'h0002);
    island_io_model_i.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
    axi_wr(`OFF_CTRL, 32'h0000_0002);
    island_io_model_i.pulse(1);
    chk_cnt(16'h0002);
    axi_wr(`OFF_CTRL, 32'h0000_0003);
    island_io_model_i.pulse(1);
    chk_cnt(16'h0002);
    axi_wr(`OFF_CTRL, 32'h0000_000C);
    island_io_model_i.pulse(1);
    chk_cnt(16'h0001);
    axi_rd(`OFF_CTRL);
    chk("ctrl", 32'h0000_000C, rd);
    axi_wr(`OFF_COUNT, 32'h0000_1234);
    chk("bresp ro", {30'h0, `RESP_OKAY}, {30'h0, resp});
    chk_cnt(16'h0001);
    // Only the low byte of the preset is replaced, then reset low loads it.
    axi_wr(`OFF_PRESET, 32'h0000_AB12, 4'h1);
    axi_rd(`OFF_PRESET);
    chk("preset strobe", 32'h0000_FF12, rd);
    island_io_model_i.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
    chk_cnt(16'hFF12);
    // An unmapped address is refused on both channels.
    axi_wr(4'h2, 32'h0000_0055);
    chk("bresp bad", {30'h0, `RESP_SLVERR}, {30'h0, resp});
    axi_rd(4'h2);
    chk("rresp bad", {30'h0, `RESP_SLVERR}, {30'h0, rd_resp});
    chk("rdata bad", 32'h0000_0000, rd);
  endtask

  // Ends the run with the verdict.
  task automatic final_report();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset for 12 cycles, then every scenario in turn.
  initial begin
    // Bus inputs idle and reset high before the first edge.
    rst <= 1'b1;
    s_axi_awaddr <= 4'h0;
    s_axi_awvalid <= 1'b0;
    s_axi_wdata <= 32'h0000_0000;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_araddr <= 4'h0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    s_reset();
    s_up_wrap();
    s_down_reset();
    s_enable();
    s_fault();
    s_modes();
    final_report();
  end

  // The scenarios need a few hundred cycles; 20000 cycles means a hang.
  initial begin
    #1000000;
    mismatches++;
    final_report();
  end
endmodule

`default_nettype wire
